// File: hdl/adc_cfg_defines.svh
`ifndef ADC_CFG_DEFINES_SVH
`define ADC_CFG_DEFINES_SVH
`define ADDR_TRIM_HIGH 8'h03
`define ADDR_TRIM_LOW 8'h04
`define ADDR_CONTROL 8'h05
`define ADDR_TEMP 8'h08
`define CTRL_STAGGER 1
`define CTRL_EXTREF 2
`define CTRL_TWOS 3
`define CTRL_SYNC 4
`define CTRL_PWRDN 6
`define CTRL_TEMPEN 7
`define CTRL_RSVD_ZERO 0
`define CTRL_RSVD_ONE 5
`define CTRL_RESET 8'h20
`define CTRL_FIXED_MASK 8'hDE
`define CTRL_FIXED_SET 8'h20
`endif

// File: hdl/adc_cfg_pkg.sv
package adc_cfg_pkg;
    typedef struct packed {
        logic tempEnable;
        logic powerDown;
        logic syncMode;
        logic twosComplement;
        logic externalRef;
        logic staggerBus;
    } mode_t;
    typedef enum logic [1:0] {
        CODE_OFFSET_BINARY,
        CODE_TWOS_COMPLEMENT
    } coding_t;
endpackage : adc_cfg_pkg

// File: hdl/offset_trim_map.sv
`timescale 1ns/100ps
// trim code to signed offset steps, monotonic, zero centred at mid-code
module offset_trim_map #(
    parameter int TRIM_WIDTH = 9
) (
    // trim code
    input wire logic [TRIM_WIDTH-1:0] trimCode,
    // signed offset in resolution steps
    output logic signed [TRIM_WIDTH:0] offsetSteps
);
    // code minus half scale less one: all zeros most negative, all ones most positive
    assign offsetSteps = $signed({1'b0, trimCode}) -
        $signed({2'b00, {(TRIM_WIDTH-1){1'b1}}});
endmodule : offset_trim_map

// File: hdl/adc_offset_and_mode_config.sv
`timescale 1ns/100ps
`include "adc_cfg_defines.svh"
module adc_offset_and_mode_config #(
    parameter int TRIM_WIDTH = 9
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // per-device factory trim, stable strap
    input wire logic [TRIM_WIDTH-1:0] factoryTrim,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    // die temperature from sensor, same clock
    input wire logic [7:0] dieTemp,
    // converter controls
    output logic [TRIM_WIDTH-1:0] trimCode,
    output logic signed [TRIM_WIDTH:0] offsetSteps,
    output adc_cfg_pkg::mode_t mode,
    output adc_cfg_pkg::coding_t coding,
    output logic tempValid
);
    logic [TRIM_WIDTH-1:0] trim_r;
    logic [TRIM_WIDTH-1:0] trim_nxt;
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic hitHigh, hitLow, hitCtrl, hitTemp;
    logic lowWrite;
    logic highWrite;
    logic ctrlWrite;

    // address decode
    assign hitHigh = regAddr == `ADDR_TRIM_HIGH;
    assign hitLow = regAddr == `ADDR_TRIM_LOW;
    assign hitCtrl = regAddr == `ADDR_CONTROL;
    assign hitTemp = regAddr == `ADDR_TEMP;
    assign lowWrite = regWrite && hitLow;
    assign highWrite = regWrite && hitHigh;
    assign ctrlWrite = regWrite && hitCtrl;

    // each trim register replaces only its own slice of the word
    assign trim_nxt = lowWrite ? {trim_r[TRIM_WIDTH-1:8], regWdata} :
        highWrite ? {regWdata[0], trim_r[TRIM_WIDTH-2:0]} : trim_r;

    // reset loads the per-device factory trim, not a shared constant
    always_ff @(posedge clock) begin
        if (reset) begin
            trim_r <= factoryTrim;
        end else begin
            trim_r <= trim_nxt;
        end
    end

    // reserved bits held at their fixed levels whatever is written
    assign ctrl_nxt = ctrlWrite ? ((regWdata & `CTRL_FIXED_MASK) | `CTRL_FIXED_SET) :
        ctrl_r;

    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl_r <= `CTRL_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // read mux: unmapped or gated addresses answer zero
    assign tempValid = ctrl_r[`CTRL_TEMPEN];
    assign rdata_nxt = !regRead ? 8'h00 :
        hitLow ? trim_r[7:0] :
        hitHigh ? {7'h00, trim_r[TRIM_WIDTH-1]} :
        hitCtrl ? ctrl_r :
        (hitTemp && tempValid) ? dieTemp : 8'h00;

    always_ff @(posedge clock) begin
        if (reset) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end
    assign regRdata = rdata_r;

    assign trimCode = trim_r;
    // decoded control fields, one driver for the whole struct
    assign mode = '{
        tempEnable: ctrl_r[`CTRL_TEMPEN],
        powerDown: ctrl_r[`CTRL_PWRDN],
        syncMode: ctrl_r[`CTRL_SYNC],
        twosComplement: ctrl_r[`CTRL_TWOS],
        externalRef: ctrl_r[`CTRL_EXTREF],
        staggerBus: ctrl_r[`CTRL_STAGGER]
    };
    assign coding = ctrl_r[`CTRL_TWOS] ? adc_cfg_pkg::CODE_TWOS_COMPLEMENT
        : adc_cfg_pkg::CODE_OFFSET_BINARY;

    offset_trim_map #(.TRIM_WIDTH(TRIM_WIDTH)) trimMap (
        .trimCode(trim_r),
        .offsetSteps(offsetSteps)
    );

    property p_trim_reset;
        @(posedge clock) reset |=> trimCode == $past(factoryTrim);
    endproperty
    a_trim_reset: assert property (p_trim_reset) else $error("trim not factory");

    property p_low_write;
        @(posedge clock) disable iff (reset)
        regWrite && hitLow |=> trimCode[7:0] == $past(regWdata);
    endproperty
    a_low_write: assert property (p_low_write) else $error("low trim lost");

    property p_high_write;
        @(posedge clock) disable iff (reset)
        regWrite && hitHigh |=> trimCode[TRIM_WIDTH-1] == $past(regWdata[0]);
    endproperty
    a_high_write: assert property (p_high_write) else $error("high trim lost");

    // code extremes map to the offset extremes
    property p_extremes;
        @(posedge clock) (trimCode == 9'h1FF |-> offsetSteps == 10'sh100) and
        (trimCode == 9'h000 |-> offsetSteps == -10'sh0FF);
    endproperty
    a_extremes: assert property (p_extremes) else $error("offset map wrong");

    // one code up moves one resolution step; the top code is kept out, it wraps
    property p_step;
        @(posedge clock) disable iff (reset)
        $past(trimCode) != {TRIM_WIDTH{1'b1}} && trimCode == $past(trimCode) + 9'h001
            |-> offsetSteps == $past(offsetSteps) + 10'sh001;
    endproperty
    a_step: assert property (p_step) else $error("step not one");

    property p_ctrl_write;
        @(posedge clock) disable iff (reset)
        ctrlWrite |=> mode.staggerBus == $past(regWdata[`CTRL_STAGGER]) &&
            mode.externalRef == $past(regWdata[`CTRL_EXTREF]) &&
            mode.twosComplement == $past(regWdata[`CTRL_TWOS]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("mode bits wrong");

    property p_reserved;
        @(posedge clock) disable iff (reset)
        ##1 ctrl_r[`CTRL_RSVD_ZERO] == 1'b0 && ctrl_r[`CTRL_RSVD_ONE] == 1'b1;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits moved");

    property p_temp;
        @(posedge clock) disable iff (reset)
        regRead && hitTemp && !tempValid |=> regRdata == 8'h00;
    endproperty
    a_temp: assert property (p_temp) else $error("temp read while off");

    // read answers stand in the cycle after the strobe
    sequence s_low_read;
        regRead && hitLow;
    endsequence
    property p_low_read;
        @(posedge clock) disable iff (reset)
        s_low_read |=> regRdata == $past(trimCode[7:0]);
    endproperty
    a_low_read: assert property (p_low_read) else $error("low trim read wrong");

    sequence s_high_read;
        regRead && hitHigh;
    endsequence
    property p_high_read;
        @(posedge clock) disable iff (reset)
        s_high_read |=> regRdata == {7'h00, $past(trimCode[TRIM_WIDTH-1])};
    endproperty
    a_high_read: assert property (p_high_read) else $error("high trim read wrong");

    sequence s_ctrl_read;
        regRead && hitCtrl;
    endsequence
    property p_ctrl_read;
        @(posedge clock) disable iff (reset)
        s_ctrl_read |=> regRdata == $past(ctrl_r);
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

    sequence s_temp_read;
        regRead && hitTemp && tempValid;
    endsequence
    property p_temp_read;
        @(posedge clock) disable iff (reset)
        s_temp_read |=> regRdata == $past(dieTemp);
    endproperty
    a_temp_read: assert property (p_temp_read) else $error("temp read wrong");

    // no strobe, no data: the read bus idles at zero
    property p_idle_read;
        @(posedge clock) disable iff (reset)
        !regRead |=> regRdata == 8'h00;
    endproperty
    a_idle_read: assert property (p_idle_read) else $error("read bus not idle");

    property p_coding;
        @(posedge clock) disable iff (reset)
        ctrlWrite |=> (coding == adc_cfg_pkg::CODE_TWOS_COMPLEMENT) ==
            $past(regWdata[`CTRL_TWOS]);
    endproperty
    a_coding: assert property (p_coding) else $error("coding wrong");

    property p_temp_enable;
        @(posedge clock) disable iff (reset)
        ctrlWrite |=> tempValid == $past(regWdata[`CTRL_TEMPEN]);
    endproperty
    a_temp_enable: assert property (p_temp_enable) else $error("temp enable wrong");

    // trim and control hold between their own writes
    property p_trim_hold;
        @(posedge clock) disable iff (reset)
        !lowWrite && !highWrite |=> $stable(trimCode);
    endproperty
    a_trim_hold: assert property (p_trim_hold) else $error("trim moved");

    property p_ctrl_hold;
        @(posedge clock) disable iff (reset)
        !ctrlWrite |=> $stable(mode) && $stable(coding) && $stable(tempValid);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold) else $error("control moved");
endmodule : adc_offset_and_mode_config

// File: verification/adc_offset_and_mode_config_bench.sv
`timescale 1ns/100ps
module adc_offset_and_mode_config_bench;
    logic clock = 0;
    logic reset = 1;
    logic [8:0] factoryTrim;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic regWrite = 0;
    logic regRead = 0;
    logic [7:0] regRdata;
    logic [7:0] dieTemp;
    logic [8:0] trimCode;
    logic signed [9:0] offsetSteps;
    adc_cfg_pkg::mode_t mode;
    adc_cfg_pkg::coding_t coding;
    logic tempValid;
    logic readSeen = 0;
    logic [7:0] expQ[$];
    int err_total = 0;
    int tests_run = 0;
    int seed = 4559;
    logic [8:0] codes[4] = '{9'h000, 9'h001, 9'h0FF, 9'h1FF};
    adc_offset_and_mode_config uut (.clock(clock), .reset(reset), .factoryTrim(factoryTrim),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .dieTemp(dieTemp), .trimCode(trimCode), .offsetSteps(offsetSteps),
        .mode(mode), .coding(coding), .tempValid(tempValid));
    initial begin
        forever #25 clock = ~clock;
    end
    task automatic chk(input string n, input logic [9:0] e, input logic [9:0] s);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regWrite <= 1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clock);
        regWrite <= 0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        regRead <= 1;
        regAddr <= a;
        expQ.push_back(e);
        @(posedge clock);
        regRead <= 0;
    endtask : rd
    // read data stand only in the cycle after the strobe
    always @(posedge clock) begin
        if (readSeen) chk("regRdata", {2'b00, expQ.pop_front()}, {2'b00, regRdata});
        readSeen <= regRead;
    end
    task automatic end_sim;
        $display("errors %0d checks %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    initial begin
        #200000;
        err_total++;
        end_sim();
    end
    initial begin
        factoryTrim <= 9'($random(seed));
        dieTemp <= 8'($random(seed));
        repeat (12) @(posedge clock);
        reset <= 0;
        #1;
        chk("trimCode", {1'b0, factoryTrim}, {1'b0, trimCode});
        rd(8'h04, factoryTrim[7:0]);
        rd(8'h03, {7'h00, factoryTrim[8]});
        rd(8'h05, 8'h20);
        foreach (codes[i]) begin
            wr(8'h03, {7'h00, codes[i][8]});
            wr(8'h04, codes[i][7:0]);
            chk("trimCode", {1'b0, codes[i]}, {1'b0, trimCode});
            chk("offsetSteps", {1'b0, codes[i]} - 10'h0FF, offsetSteps);
            rd(8'h04, codes[i][7:0]);
        end
        for (int i = 1; i < 4; i++) begin
            wr(8'h05, 8'h20 | (8'h01 << i));
            chk("mode", 10'(6'h01 << (i - 1)), 10'(mode));
            chk("coding", (i == 3) ? 10'(adc_cfg_pkg::CODE_TWOS_COMPLEMENT)
                : 10'(adc_cfg_pkg::CODE_OFFSET_BINARY), 10'(coding));
            rd(8'h05, 8'h20 | (8'h01 << i));
        end
        wr(8'h05, 8'h70);
        chk("mode", 10'h018, 10'(mode));
        chk("tempValid", 10'h000, {9'h000, tempValid});
        rd(8'h08, 8'h00);
        wr(8'h05, 8'hA0);
        chk("tempValid", 10'h001, {9'h000, tempValid});
        chk("mode", 10'h020, 10'(mode));
        rd(8'h08, dieTemp);
        rd(8'h07, 8'h00);
        // mid-run reset restores factory trim and control defaults
        wr(8'h04, 8'h5A);
        @(posedge clock);
        reset <= 1;
        repeat (3) @(posedge clock);
        reset <= 0;
        #1;
        chk("trimCode", {1'b0, factoryTrim}, {1'b0, trimCode});
        chk("mode", 10'h000, 10'(mode));
        chk("tempValid", 10'h000, {9'h000, tempValid});
        rd(8'h05, 8'h20);
        rd(8'h04, factoryTrim[7:0]);
        rd(8'h07, 8'h00);
        repeat (3) @(posedge clock);
        end_sim();
    end
endmodule : adc_offset_and_mode_config_bench
